// File: bert_top.sv
// Bit error rate tester: generator, synchroniser, counters and AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
module bert_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // AXI4-Lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Link and control pins
  input wire logic transmit_clock,
  input wire logic receive_clock,
  input wire logic rx_data,
  input wire logic transmit_load,
  input wire logic load_count,
  input wire logic tx_gate,
  input wire logic rx_gate,
  output logic tx_data
);
  logic [31:0] pattern_set_regs;
  logic [4:0] pattern_length_reg;
  logic [4:0] polynomial_tap_reg;
  logic [7:0] pattern_control_reg;
  logic [3:0] error_insert_reg;
  logic count_control_reg;
  logic resync_reg;
  logic single_req_reg;
  logic [6:0] pins;
  logic [6:0] pins_prev_reg;
  logic tx_clk_lvl, rx_clk_lvl, rx_bit, tl_lvl, lc_lvl, txg_lvl, rxg_lvl;
  logic load_or_reg;
  logic lc_or_reg;
  logic load_trig, lc_trig, tx_step, tx_rise, rx_step;
  logic [1:0] load_cnt_reg;
  logic running_reg;
  logic [31:0] gen_reg;
  logic [31:0] gen_next;
  logic [23:0] rate_cnt_reg;
  logic single_pend_reg;
  logic rate_hit, inject;
  logic [31:0] rx_sr_reg;
  logic predicted, mismatch;
  logic [6:0] ok_cnt_reg;
  logic [6:0] sync_thr;
  logic in_sync_reg;
  logic [31:0] run_bits_reg;
  logic [31:0] run_errs_reg;
  logic [31:0] bit_count_reg;
  logic [31:0] bit_error_count_reg;
  logic [31:0] len_mask;
  logic wr_fire, rd_fire;
  logic [7:0] wa, ra;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                       input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Bits between inserted errors for each rate code
  function automatic logic [23:0] rate_period(input logic [2:0] code);
    case (code)
      3'h1: rate_period = 24'h00000A;
      3'h2: rate_period = 24'h000064;
      3'h3: rate_period = 24'h0003E8;
      3'h4: rate_period = 24'h002710;
      3'h5: rate_period = 24'h0186A0;
      3'h6: rate_period = 24'h0F4240;
      3'h7: rate_period = 24'h989680;
      default: rate_period = 24'h000000;
    endcase
  endfunction

  // Pin synchroniser for all asynchronous inputs
  assign pins = {rxg_lvl, txg_lvl, lc_lvl, tl_lvl, rx_bit, rx_clk_lvl, tx_clk_lvl};
  pin_sync #(.W(7)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin_in({rx_gate, tx_gate, load_count, transmit_load, rx_data, receive_clock,
             transmit_clock}),
    .level_out({rxg_lvl, txg_lvl, lc_lvl, tl_lvl, rx_bit, rx_clk_lvl, tx_clk_lvl})
  );

  // Edge history of filtered levels and OR of pin and register controls
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pins_prev_reg <= '0;
      load_or_reg <= 1'b0;
      lc_or_reg <= 1'b0;
    end else begin
      pins_prev_reg <= pins;
      load_or_reg <= tl_lvl | pattern_control_reg[bert_pkg::PC_LOAD];
      lc_or_reg <= lc_lvl | count_control_reg;
    end
  end
  assign tx_rise = tx_clk_lvl & ~pins_prev_reg[0];
  assign tx_step = tx_rise & txg_lvl;
  assign rx_step = rx_clk_lvl & ~pins_prev_reg[1] & rxg_lvl;
  assign load_trig = (tl_lvl | pattern_control_reg[bert_pkg::PC_LOAD]) & ~load_or_reg;
  assign lc_trig = (lc_lvl | count_control_reg) & ~lc_or_reg;

  // AXI4-Lite handshakes: write takes address and data together
  assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
  assign rd_fire = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  assign wa = 8'(s_axi_awaddr);
  assign ra = 8'(s_axi_araddr);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bert_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= wr_fire;
      s_axi_wready <= wr_fire;
      if (wr_fire) begin
        s_axi_bresp <= (wa[1:0] == 2'h0 && wa <= bert_pkg::OFS_COUNT_CONTROL) ?
                       bert_pkg::RESP_OKAY : bert_pkg::RESP_SLVERR;
      end
      // Response raised only after both write channels have been taken
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; resync and single insert are self-clearing pulses
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pattern_set_regs <= bert_pkg::RST_PATTERN;
      pattern_length_reg <= bert_pkg::RST_LENGTH;
      polynomial_tap_reg <= bert_pkg::RST_TAP;
      pattern_control_reg <= bert_pkg::RST_CONTROL;
      error_insert_reg <= bert_pkg::RST_ERR_INS;
      count_control_reg <= 1'b0;
      resync_reg <= 1'b0;
      single_req_reg <= 1'b0;
    end else begin
      resync_reg <= 1'b0;
      single_req_reg <= 1'b0;
      if (wr_fire) begin
        unique case (wa)
          bert_pkg::OFS_PATTERN_SET:
            pattern_set_regs <= merge(pattern_set_regs, s_axi_wdata, s_axi_wstrb);
          bert_pkg::OFS_PATTERN_LENGTH: if (s_axi_wstrb[0]) begin
            pattern_length_reg <= s_axi_wdata[4:0];
          end
          bert_pkg::OFS_POLY_TAP: if (s_axi_wstrb[0]) begin
            polynomial_tap_reg <= s_axi_wdata[4:0];
          end
          bert_pkg::OFS_PATTERN_CONTROL: if (s_axi_wstrb[0]) begin
            pattern_control_reg <= s_axi_wdata[7:0] & 8'hFB;
            resync_reg <= s_axi_wdata[bert_pkg::PC_RESYNC];
          end
          bert_pkg::OFS_ERROR_INSERT: if (s_axi_wstrb[0]) begin
            error_insert_reg <= {1'b0, s_axi_wdata[2:0]};
            single_req_reg <= s_axi_wdata[bert_pkg::EI_SINGLE];
          end
          bert_pkg::OFS_COUNT_CONTROL: if (s_axi_wstrb[0]) begin
            count_control_reg <= s_axi_wdata[bert_pkg::CC_LOAD_COUNT];
          end
          default: ;
        endcase
      end
    end
  end

  // Register reads
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= bert_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= rd_fire;
      // Read data offered only after the address has been taken
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_axi_rresp <= bert_pkg::RESP_OKAY;
        unique case (ra)
          bert_pkg::OFS_PATTERN_SET: s_axi_rdata <= pattern_set_regs;
          bert_pkg::OFS_PATTERN_LENGTH: s_axi_rdata <= {27'h0, pattern_length_reg};
          bert_pkg::OFS_POLY_TAP: s_axi_rdata <= {27'h0, polynomial_tap_reg};
          bert_pkg::OFS_PATTERN_CONTROL: s_axi_rdata <= {24'h0, pattern_control_reg};
          bert_pkg::OFS_ERROR_INSERT: s_axi_rdata <= {28'h0, error_insert_reg};
          bert_pkg::OFS_STATUS: s_axi_rdata <= {29'h0, (rx_sr_reg & len_mask) == len_mask,
            (rx_sr_reg & len_mask) == 32'h0000_0000, in_sync_reg};
          bert_pkg::OFS_PATTERN_RECEIVE: s_axi_rdata <= rx_sr_reg & len_mask;
          bert_pkg::OFS_BIT_ERROR_COUNT: s_axi_rdata <= bit_error_count_reg;
          bert_pkg::OFS_BIT_COUNT: s_axi_rdata <= bit_count_reg;
          bert_pkg::OFS_COUNT_CONTROL: s_axi_rdata <= {31'h0, count_control_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= bert_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Next generator state: tap A at N-1, tap B programmable
  always_comb begin
    gen_next = {gen_reg[30:0], 1'b0};
    if (pattern_control_reg[bert_pkg::PC_REPETITIVE]) begin
      gen_next[0] = gen_reg[pattern_length_reg];
    end else begin
      gen_next[0] = gen_reg[pattern_length_reg] ^ gen_reg[polynomial_tap_reg];
    end
  end
  assign rate_hit = (error_insert_reg[2:0] != 3'h0) &&
                    (rate_cnt_reg + 24'h1 >= rate_period(error_insert_reg[2:0]));
  assign inject = single_pend_reg | rate_hit;

  // Transmit generator with three-edge load delay and output error inversion
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      load_cnt_reg <= 2'h0;
      running_reg <= 1'b0;
      gen_reg <= 32'h0000_0000;
      tx_data <= 1'b0;
    end else if (load_trig) begin
      load_cnt_reg <= bert_pkg::LOAD_EDGES;
    end else if (tx_rise && load_cnt_reg != 2'h0) begin
      load_cnt_reg <= load_cnt_reg - 2'h1;
      if (load_cnt_reg == 2'h1) begin
        gen_reg <= pattern_set_regs;
        running_reg <= 1'b1;
        tx_data <= pattern_set_regs[pattern_length_reg];
      end
    end else if (tx_step && running_reg) begin
      gen_reg <= gen_next;
      tx_data <= gen_next[pattern_length_reg] ^ inject;
    end
  end

  // Error insertion timing; a new single request wins over its consumption
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rate_cnt_reg <= 24'h0;
      single_pend_reg <= 1'b0;
    end else begin
      if (error_insert_reg[2:0] == 3'h0) begin
        rate_cnt_reg <= 24'h0; // Rate off: next rate starts a full period
      end else if (tx_step && running_reg && load_cnt_reg == 2'h0 && !load_trig) begin
        rate_cnt_reg <= rate_hit ? 24'h0 : rate_cnt_reg + 24'h1;
      end
      if (single_req_reg) begin
        single_pend_reg <= 1'b1;
      end else if (tx_step && running_reg && load_cnt_reg == 2'h0 && !load_trig) begin
        single_pend_reg <= 1'b0;
      end
    end
  end

  // Receive prediction from the same polynomial or repeat length
  assign predicted = pattern_control_reg[bert_pkg::PC_REPETITIVE] ?
                     rx_sr_reg[pattern_length_reg] :
                     rx_sr_reg[pattern_length_reg] ^ rx_sr_reg[polynomial_tap_reg];
  assign mismatch = rx_bit ^ predicted;
  assign sync_thr = bert_pkg::SYNC_EXTRA + {2'h0, pattern_length_reg} + 7'h01;
  assign len_mask = 32'hFFFF_FFFF >> (5'h1F - pattern_length_reg);

  // Synchroniser: hunt on raw bits, then self-run on predicted bits
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_sr_reg <= 32'h0000_0000;
      ok_cnt_reg <= 7'h00;
      in_sync_reg <= 1'b0;
    end else if (resync_reg || !pattern_control_reg[bert_pkg::PC_SYNC_ENABLE]) begin
      ok_cnt_reg <= 7'h00;
      in_sync_reg <= 1'b0;
      if (rx_step) begin
        rx_sr_reg <= {rx_sr_reg[30:0], rx_bit};
      end
    end else if (rx_step) begin
      if (in_sync_reg) begin
        rx_sr_reg <= {rx_sr_reg[30:0], predicted};
      end else begin
        rx_sr_reg <= {rx_sr_reg[30:0], rx_bit};
        if (ok_cnt_reg >= sync_thr) begin
          in_sync_reg <= 1'b1;
        end else begin
          ok_cnt_reg <= mismatch ? 7'h00 : ok_cnt_reg + 7'h01;
        end
      end
    end
  end

  // Running counters, latched and cleared by the load count control
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      run_bits_reg <= 32'h0;
      run_errs_reg <= 32'h0;
      bit_count_reg <= 32'h0;
      bit_error_count_reg <= 32'h0;
    end else if (lc_trig) begin
      bit_count_reg <= run_bits_reg;
      bit_error_count_reg <= run_errs_reg;
      run_bits_reg <= 32'h0;
      run_errs_reg <= 32'h0;
    end else if (rx_step && in_sync_reg) begin
      run_bits_reg <= run_bits_reg + 32'h1;
      run_errs_reg <= run_errs_reg + {31'h0, mismatch};
    end
  end

  // Checks
  sequence s_load_armed;
    load_trig ##1 (load_cnt_reg == 2'h3);
  endsequence
  property p_load_or;
    @(posedge ref_clk) disable iff (srst)
      $rose(tl_lvl | pattern_control_reg[bert_pkg::PC_LOAD]) |-> s_load_armed;
  endproperty
  a_load_or: assert property (p_load_or) else $error("load trigger missed");
  property p_msb_out;
    @(posedge ref_clk) disable iff (srst)
      (tx_rise && load_cnt_reg == 2'h1 && !load_trig) |=>
        (running_reg && tx_data == $past(pattern_set_regs[pattern_length_reg]));
  endproperty
  a_msb_out: assert property (p_msb_out) else $error("msb not sent on third edge");
  property p_feedback;
    @(posedge ref_clk) disable iff (srst)
      (tx_step && running_reg && load_cnt_reg == 2'h0 && !load_trig &&
       !pattern_control_reg[bert_pkg::PC_REPETITIVE]) |=>
        gen_reg[0] == ($past(gen_reg[pattern_length_reg]) ^ $past(gen_reg[polynomial_tap_reg]));
  endproperty
  a_feedback: assert property (p_feedback) else $error("bad feedback bit");
  property p_repeat;
    @(posedge ref_clk) disable iff (srst)
      (tx_step && running_reg && load_cnt_reg == 2'h0 && !load_trig &&
       pattern_control_reg[bert_pkg::PC_REPETITIVE]) |=>
        gen_reg[0] == $past(gen_reg[pattern_length_reg]);
  endproperty
  a_repeat: assert property (p_repeat) else $error("pattern does not repeat");
  property p_inject;
    @(posedge ref_clk) disable iff (srst)
      (tx_step && running_reg && load_cnt_reg == 2'h0 && !load_trig && inject) |=>
        tx_data != gen_reg[pattern_length_reg];
  endproperty
  a_inject: assert property (p_inject) else $error("error not inverted");
  property p_sync_count;
    @(posedge ref_clk) disable iff (srst)
      $rose(in_sync_reg) |-> $past(ok_cnt_reg) >= $past(sync_thr);
  endproperty
  a_sync_count: assert property (p_sync_count) else $error("sync too early");
  property p_err_count;
    @(posedge ref_clk) disable iff (srst)
      (rx_step && in_sync_reg && mismatch && !lc_trig) |=>
        run_errs_reg == $past(run_errs_reg) + 32'h1;
  endproperty
  a_err_count: assert property (p_err_count) else $error("error not counted");
  property p_bit_count;
    @(posedge ref_clk) disable iff (srst)
      (!in_sync_reg && !lc_trig) |=> run_bits_reg == $past(run_bits_reg);
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("bits counted out of sync");
  property p_resync;
    @(posedge ref_clk) disable iff (srst)
      resync_reg |=> (!in_sync_reg && ok_cnt_reg == 7'h00);
  endproperty
  a_resync: assert property (p_resync) else $error("resync ignored");
endmodule
`default_nettype wire

// File: bert_pkg.sv
// Package with register map, field positions, reset values and timing counts of the bit error rate tester
package bert_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_PATTERN_SET = 8'h00;
  localparam logic [7:0] OFS_PATTERN_LENGTH = 8'h04;
  localparam logic [7:0] OFS_POLY_TAP = 8'h08;
  localparam logic [7:0] OFS_PATTERN_CONTROL = 8'h0C;
  localparam logic [7:0] OFS_ERROR_INSERT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_PATTERN_RECEIVE = 8'h18;
  localparam logic [7:0] OFS_BIT_ERROR_COUNT = 8'h1C;
  localparam logic [7:0] OFS_BIT_COUNT = 8'h20;
  localparam logic [7:0] OFS_COUNT_CONTROL = 8'h24;
  // Pattern control fields
  localparam int PC_REPETITIVE = 0;
  localparam int PC_SYNC_ENABLE = 1;
  localparam int PC_RESYNC = 2;
  localparam int PC_LOAD = 7;
  // Error insert fields
  localparam int EI_RATE_LSB = 0;
  localparam int EI_SINGLE = 3;
  // Status fields
  localparam int ST_IN_SYNC = 0;
  localparam int ST_IND_LO = 1;
  localparam int ST_IND_HI = 2;
  // Count control field
  localparam int CC_LOAD_COUNT = 0;
  // Reset values
  localparam logic [31:0] RST_PATTERN = 32'h0000_0000;
  localparam logic [4:0] RST_LENGTH = 5'h00;
  localparam logic [4:0] RST_TAP = 5'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [3:0] RST_ERR_INS = 4'h0;
  // Timing counts
  localparam logic [1:0] LOAD_EDGES = 2'h3;
  localparam logic [6:0] SYNC_EXTRA = 7'h22;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: pin_sync.sv
// Three-stage input synchroniser with agreement filter for a group of pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // Raw pins and filtered levels
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // Shift chain; a change is taken once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level_out <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_out <= (s3_reg & ~(s2_reg ^ s3_reg)) | (level_out & (s2_reg ^ s3_reg));
    end
  end
endmodule
`default_nettype wire

// File: bert_channel.sv
// Looped-back channel model that clocks the link and returns transmitted bits
`timescale 1ns/1ns
`default_nettype none
module bert_channel (
  // Link pins
  output logic link_clk,
  output logic rx_bit,
  input wire logic tx_bit,
  // Received bit positions to corrupt
  input wire logic [63:0] flip_map
);
  logic cap [0:127];
  // Link clock stands low between runs
  initial begin
    link_clk = 1'b0;
    rx_bit = 1'b0;
  end
  // One 125 ns clock per bit; bit k is captured and echoed on its falling edge
  task automatic run(input int n);
    #1; // Keep link edges off the system clock edge
    for (int k = 0; k < n; k++) begin
      link_clk = 1'b1;
      #63;
      link_clk = 1'b0;
      cap[k] = tx_bit;
      rx_bit = tx_bit ^ ((k < 64) ? flip_map[k] : 1'b0);
      #62;
    end
  endtask
endmodule
`default_nettype wire

// File: bit_error_rate_tester_bench.sv
// Self-checking bench: AXI4-Lite host tasks and looped-back link scenarios
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("unexpected at %0t got %h exp %h", $time, (g), (e)); \
  end \
end
module bit_error_rate_tester_bench;
  // Bench signals
  logic ref_clk, srst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic lclk, rxd, txd, tload, lcnt, tgate, rgate;
  logic [7:0] awa, ara;
  logic [3:0] ws;
  logic [31:0] wd, rdat, d;
  logic [1:0] bresp, rresp, r;
  logic [63:0] flips;
  int err_total, check_count;
  // Device and channel
  bert_top u_dut (.ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .transmit_clock(lclk),
    .receive_clock(lclk), .rx_data(rxd), .transmit_load(tload), .load_count(lcnt),
    .tx_gate(tgate), .rx_gate(rgate), .tx_data(txd));
  bert_channel u_chan (.link_clk(lclk), .rx_bit(rxd), .tx_bit(txd), .flip_map(flips));
  // System clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Write: each channel held until taken, response awaited with bready high
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
    int n;
    n = 0;
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 50);
    s = bresp;
    br <= 1'b0;
    if (n >= 50) err_total++;
    @(posedge ref_clk);
  endtask
  // Read: address held until taken, data taken at the rvalid edge
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 50);
    v = rdat;
    s = rresp;
    rr <= 1'b0;
    if (n >= 50) err_total++;
    @(posedge ref_clk);
  endtask
  // Write expecting OKAY, and plain read into d
  task automatic put(input logic [7:0] a, input logic [31:0] v);
    axi_wr(a, v, r);
    `CHK(r, bert_pkg::RESP_OKAY)
  endtask
  task automatic get(input logic [7:0] a);
    axi_rd(a, d, r);
  endtask
  // Latch counters from the pin, after in-flight bits have settled
  task automatic latch_pin();
    repeat (20) @(posedge ref_clk);
    lcnt <= 1'b1;
    repeat (12) @(posedge ref_clk);
    lcnt <= 1'b0;
    repeat (12) @(posedge ref_clk);
  endtask
  // Latch and clear counters through the control bit
  task automatic latch_reg();
    repeat (20) @(posedge ref_clk);
    put(bert_pkg::OFS_COUNT_CONTROL, 32'h0000_0001);
    put(bert_pkg::OFS_COUNT_CONTROL, 32'h0000_0000);
  endtask
  // Program every setting, then load from the pin or the control bit
  task automatic prog(input logic [31:0] p, input logic [4:0] nm1, input logic [4:0] tap,
                      input logic [7:0] c, input logic pin);
    put(bert_pkg::OFS_PATTERN_SET, p);
    put(bert_pkg::OFS_PATTERN_LENGTH, {27'h0, nm1});
    put(bert_pkg::OFS_POLY_TAP, {27'h0, tap});
    put(bert_pkg::OFS_ERROR_INSERT, 32'h0);
    put(bert_pkg::OFS_PATTERN_CONTROL, {24'h0, c | (pin ? 8'h00 : 8'h80)});
    tload <= pin;
    repeat (12) @(posedge ref_clk);
    tload <= 1'b0;
    put(bert_pkg::OFS_PATTERN_CONTROL, {24'h0, c});
    repeat (12) @(posedge ref_clk);
  endtask
  // Predicted transmit stream, MSB first from the third rise
  task automatic tx_check(input logic [31:0] p, input int n, input int tap, input logic rep,
                          input int cnt);
    logic [31:0] g;
    g = p;
    for (int i = 0; i < cnt; i++) begin
      `CHK(u_chan.cap[i + 2], g[n - 1])
      g = {g[30:0], rep ? g[n - 1] : g[n - 1] ^ g[tap]};
    end
  endtask
  // Reset values, refused addresses, self-clearing resync
  task automatic t_regs();
    get(bert_pkg::OFS_PATTERN_CONTROL);
    `CHK(d, 32'h0000_0000)
    axi_rd(8'h28, d, r);
    `CHK({r, d}, {bert_pkg::RESP_SLVERR, 32'h0000_0000})
    axi_wr(8'h2C, 32'hFFFF_FFFF, r);
    `CHK(r, bert_pkg::RESP_SLVERR)
    put(bert_pkg::OFS_PATTERN_SET, 32'hFFFF_FFFF);
    ws <= 4'h3;
    put(bert_pkg::OFS_PATTERN_SET, 32'h1234_5678);
    ws <= 4'hF;
    get(bert_pkg::OFS_PATTERN_SET);
    `CHK(d, 32'hFFFF_5678)
    put(bert_pkg::OFS_PATTERN_CONTROL, 32'h0000_0006);
    get(bert_pkg::OFS_PATTERN_CONTROL);
    `CHK(d, 32'h0000_0002)
  endtask
  // Pseudorandom stream, hunting off then on, threshold of 34 plus n
  task automatic t_prbs();
    prog(32'h0000_005B, 5'h06, 5'h05, 8'h00, 1'b0);
    u_chan.run(24);
    tx_check(32'h0000_005B, 7, 5, 1'b0, 20);
    u_chan.run(60);
    get(bert_pkg::OFS_STATUS);
    `CHK(d[bert_pkg::ST_IN_SYNC], 1'b0)
    put(bert_pkg::OFS_PATTERN_CONTROL, 32'h0000_0002);
    u_chan.run(30);
    get(bert_pkg::OFS_STATUS);
    `CHK(d[bert_pkg::ST_IN_SYNC], 1'b0)
    u_chan.run(50);
    get(bert_pkg::OFS_STATUS);
    `CHK(d[bert_pkg::ST_IN_SYNC], 1'b1)
  endtask
  // Three corrupted bits in sixty, counters latched by the pin
  task automatic t_count();
    latch_reg();
    flips <= 64'h0000_0100_0002_0020;
    u_chan.run(60);
    flips <= 64'h0;
    latch_pin();
    get(bert_pkg::OFS_BIT_ERROR_COUNT);
    `CHK(d, 32'h0000_0003)
    get(bert_pkg::OFS_BIT_COUNT);
    `CHK(d, 32'h0000_003C)
  endtask
  // Gaps: no transmit step and no received bit while gates are low
  task automatic t_gate();
    tgate <= 1'b0;
    rgate <= 1'b0;
    repeat (10) @(posedge ref_clk);
    u_chan.run(10);
    @(posedge ref_clk);
    tgate <= 1'b1;
    rgate <= 1'b1;
    latch_pin();
    get(bert_pkg::OFS_BIT_COUNT);
    `CHK(d, 32'h0000_0000)
    for (int i = 1; i < 10; i++) `CHK(u_chan.cap[i], u_chan.cap[0])
  endtask
  // Repetitive pattern loaded by the pin, resync, then error insertion
  task automatic t_rep();
    logic [7:0] e;
    prog(32'h0000_00A5, 5'h07, 5'h00, 8'h03, 1'b1);
    u_chan.run(20);
    tx_check(32'h0000_00A5, 8, 0, 1'b1, 16);
    put(bert_pkg::OFS_PATTERN_CONTROL, 32'h0000_0007);
    u_chan.run(20);
    get(bert_pkg::OFS_STATUS);
    `CHK(d[bert_pkg::ST_IN_SYNC], 1'b0)
    u_chan.run(70);
    get(bert_pkg::OFS_STATUS);
    `CHK(d, 32'h0000_0001)
    // Captured pattern is the last eight bits clocked in, bits 61 to 68 of the run
    get(bert_pkg::OFS_PATTERN_RECEIVE);
    for (int i = 61; i < 69; i++) e = {e[6:0], u_chan.cap[i]};
    `CHK(d, {24'h0, e})
    latch_reg();
    put(bert_pkg::OFS_ERROR_INSERT, 32'h0000_0008);
    u_chan.run(40);
    latch_pin();
    get(bert_pkg::OFS_BIT_ERROR_COUNT);
    `CHK(d, 32'h0000_0001)
    put(bert_pkg::OFS_ERROR_INSERT, 32'h0000_0001);
    u_chan.run(50);
    put(bert_pkg::OFS_ERROR_INSERT, 32'h0000_0000);
    latch_pin();
    get(bert_pkg::OFS_BIT_ERROR_COUNT);
    `CHK(d, 32'h0000_0004)
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    if (err_total == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Watchdog: about seven times the expected length of all scenarios
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {srst, awv, wv, br, arv, rr, tload, lcnt} = 8'h80;
    {tgate, rgate, awa, ara, wd, flips} = '0;
    tgate = 1'b1;
    rgate = 1'b1;
    ws = 4'hF;
    err_total = 0;
    check_count = 0;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    t_regs();
    t_prbs();
    t_count();
    t_gate();
    t_rep();
    wrap_up();
  end
endmodule
`undef CHK
`default_nettype wire
